// File: include/gpp_pkg.sv
// Constants and helpers shared by the general-purpose port block
package gpp_pkg;

  // ****************************************************
  // Sizes
  // ****************************************************
  localparam int NPORT    = 4;
  localparam int PW       = 8;
  localparam int PUD_STEP = 4;

  // ****************************************************
  // Register byte addresses
  // ****************************************************
  localparam logic [3:0][31:0] ADDR_DATA = {32'hFFFF0D50, 32'hFFFF0D40,
                                            32'hFFFF0D30, 32'hFFFF0D20};
  localparam logic [3:0][31:0] ADDR_SET  = {32'hFFFF0D54, 32'hFFFF0D44,
                                            32'hFFFF0D34, 32'hFFFF0D24};
  localparam logic [3:0][31:0] ADDR_CLR  = {32'hFFFF0D58, 32'hFFFF0D48,
                                            32'hFFFF0D38, 32'hFFFF0D28};
  localparam logic [3:0][31:0] ADDR_PAR  = {32'hFFFF0D5C, 32'hFFFF0D4C,
                                            32'hFFFF0D3C, 32'hFFFF0D2C};
  localparam logic [3:1][31:0] ADDR_OCE  = {32'hFFFF0D68, 32'hFFFF0D64,
                                            32'hFFFF0D60};

  // ****************************************************
  // Field positions and byte lanes
  // ****************************************************
  localparam int DIR_LSB  = 24;
  localparam int OUT_LSB  = 16;
  localparam int RST_LSB  = 8;
  localparam int IN_LSB   = 0;
  localparam int DIR_STRB = 3;
  localparam int OUT_STRB = 2;
  localparam int OCE_STRB = 0;

  // ****************************************************
  // Reset values and masks
  // ****************************************************
  localparam logic [7:0]      DIR_RST = 8'h00;
  localparam logic [7:0]      OUT_RST = 8'h00;
  localparam logic [7:0]      PUD_RST = 8'h00;
  localparam logic [7:0]      OCE_RST = 8'h00;
  localparam logic [3:0][7:0] OD_MASK = {8'hFF, 8'hFF, 8'hC0, 8'h00};

  // ****************************************************
  // Timing and bus answers
  // ****************************************************
  localparam logic [1:0] CAP_DLY     = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Gather pull-up disable bits from a word
  function automatic logic [7:0] pud_gather(input logic [31:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < PW; i++) begin
      r[i] = d[PUD_STEP*i];
    end
    return r;
  endfunction

  // Spread pull-up disable bits into a word
  function automatic logic [31:0] pud_spread(input logic [7:0] b);
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < PW; i++) begin
      r[PUD_STEP*i] = b[i];
    end
    return r;
  endfunction

endpackage

// File: include/gpp_reg_if.sv
// Register access carrier between bus slave and port registers
`timescale 1ns/100ps
interface gpp_reg_if;
  logic        wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_hit;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_hit;

  modport bus (
    output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
    input  wr_hit, rd_data, rd_hit
  );
  modport regs (
    input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
    output wr_hit, rd_data, rd_hit
  );
endinterface

// File: hdl/gpp_axil.sv
// AXI4-Lite slave front end for the port registers
`timescale 1ns/100ps
module gpp_axil
  import gpp_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Write address and data
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // Write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // Read
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Register side
  gpp_reg_if.bus           rif
);

  logic aw_full;
  logic w_full;

  // ****************************************************
  // Write channels
  // ****************************************************
  assign s_axi_awready_o = !aw_full;
  assign s_axi_wready_o  = !w_full;
  assign rif.wr_en       = aw_full && w_full && !s_axi_bvalid_o;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_full     <= 1'b0;
      rif.wr_addr <= 32'h00000000;
    end else if (s_axi_awvalid_i && !aw_full) begin
      aw_full     <= 1'b1;
      rif.wr_addr <= s_axi_awaddr_i;
    end else if (rif.wr_en) begin
      aw_full     <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      w_full      <= 1'b0;
      rif.wr_data <= 32'h00000000;
      rif.wr_strb <= 4'h0;
    end else if (s_axi_wvalid_i && !w_full) begin
      w_full      <= 1'b1;
      rif.wr_data <= s_axi_wdata_i;
      rif.wr_strb <= s_axi_wstrb_i;
    end else if (rif.wr_en) begin
      w_full      <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else if (rif.wr_en) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= rif.wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ****************************************************
  // Read channels
  // ****************************************************
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign rif.rd_addr     = s_axi_araddr_i;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h00000000;
      s_axi_rresp_o  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rif.rd_data;
      s_axi_rresp_o  <= rif.rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule

// File: hdl/gpp_port.sv
// Pin logic of one 8-bit port: input sync, reset capture, drive
`timescale 1ns/100ps
module gpp_port
  import gpp_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  // Pins
  input  wire logic [PW-1:0] pin_in_i,
  output logic [PW-1:0]      pin_out_o,
  output logic [PW-1:0]      pin_oe_o,
  output logic [PW-1:0]      pullup_en_o,
  // Controls
  input  wire logic [PW-1:0] out_i,
  input  wire logic [PW-1:0] dir_i,
  input  wire logic [PW-1:0] od_i,
  input  wire logic [PW-1:0] pud_i,
  // Status
  output logic [PW-1:0]      level_o,
  output logic [PW-1:0]      rst_level_o,
  output logic               cap_done_o
);

  logic [PW-1:0] sync1;
  logic [1:0]    cap_cnt;

  // ****************************************************
  // Input synchroniser
  // ****************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1   <= 8'h00;
      level_o <= 8'h00;
    end else begin
      sync1   <= pin_in_i;
      level_o <= sync1;
    end
  end

  // ****************************************************
  // Capture of pin levels after reset
  // ****************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_cnt     <= 2'h0;
      cap_done_o  <= 1'b0;
      rst_level_o <= 8'h00;
    end else if (!cap_done_o) begin
      if (cap_cnt == CAP_DLY) begin
        cap_done_o  <= 1'b1;
        rst_level_o <= level_o;
      end else begin
        cap_cnt <= cap_cnt + 2'h1;
      end
    end
  end

  // ****************************************************
  // Pin drive
  // ****************************************************
  always_comb begin
    pin_out_o   = out_i & ~od_i;
    pin_oe_o    = dir_i & (~od_i | ~out_i);
    pullup_en_o = ~pud_i;
  end

endmodule

// File: hdl/gpp_top.sv
// Four 8-bit general-purpose ports behind an AXI4-Lite register slave
// Operation
// RL1: Each pin has a pull-up disable bit at position four times its index.
// RL2: Data register bits 31:24 set each pin as output (1) or input (0).
// RL3: Data register bits 23:16 hold the value driven on output pins.
// RL4: Data register bits 15:8 read back the pin levels caught after reset.
// RL5: Data register bits 7:0 read back the synchronised pin levels.
// RL6: A 1 in bits 23:16 of the set register sets that output bit.
// RL7: A 1 in bits 23:16 of the clear register clears that output bit.
// RL8: Other bits of the set and clear registers do nothing.
// RL9: Open-drain exists only on port 1 pins 6-7 and all of ports 2 and 3.
// RL10: An open-drain enable bit of 1 selects open-drain drive for its pin.
// RL11: Software writes the data register after changing pull-up settings.
// RL12: Input bits show the pin level at all times, whatever the pin does.
// RL13: Pull-ups are on unless their disable bit is set.
// RL14: An open-drain output drives low for 0 and floats for 1.
`timescale 1ns/100ps
module gpp_top
  import gpp_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Port pins, port n on bits 8n+7:8n
  input  wire logic [31:0] pin_in_i,
  output logic [31:0]      pin_out_o,
  output logic [31:0]      pin_oe_o,
  output logic [31:0]      pullup_en_o
);

  // ****************************************************
  // Storage
  // ****************************************************
  gpp_reg_if rif ();

  logic [3:0][7:0] dir_q;
  logic [3:0][7:0] out_q;
  logic [3:0][7:0] pud_q;
  logic [3:0][7:0] oce_q;
  logic [3:0][7:0] level;
  logic [3:0][7:0] rst_level;
  logic [3:0]      cap_done;

  // ****************************************************
  // Bus slave
  // ****************************************************
  gpp_axil u_axil (
    .core_clk_i      (core_clk_i),
    .rst_i           (rst_i),
    .s_axi_awaddr_i  (s_axi_awaddr_i),
    .s_axi_awvalid_i (s_axi_awvalid_i),
    .s_axi_awready_o (s_axi_awready_o),
    .s_axi_wdata_i   (s_axi_wdata_i),
    .s_axi_wstrb_i   (s_axi_wstrb_i),
    .s_axi_wvalid_i  (s_axi_wvalid_i),
    .s_axi_wready_o  (s_axi_wready_o),
    .s_axi_bresp_o   (s_axi_bresp_o),
    .s_axi_bvalid_o  (s_axi_bvalid_o),
    .s_axi_bready_i  (s_axi_bready_i),
    .s_axi_araddr_i  (s_axi_araddr_i),
    .s_axi_arvalid_i (s_axi_arvalid_i),
    .s_axi_arready_o (s_axi_arready_o),
    .s_axi_rdata_o   (s_axi_rdata_o),
    .s_axi_rresp_o   (s_axi_rresp_o),
    .s_axi_rvalid_o  (s_axi_rvalid_o),
    .s_axi_rready_i  (s_axi_rready_i),
    .rif             (rif.bus)
  );

  // ****************************************************
  // Address decode
  // ****************************************************
  always_comb begin
    rif.wr_hit = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      if (rif.wr_addr == ADDR_DATA[p] || rif.wr_addr == ADDR_SET[p] ||
          rif.wr_addr == ADDR_CLR[p] || rif.wr_addr == ADDR_PAR[p]) begin
        rif.wr_hit = 1'b1;
      end
    end
    for (int p = 1; p < NPORT; p++) begin
      if (rif.wr_addr == ADDR_OCE[p]) begin
        rif.wr_hit = 1'b1;
      end
    end
  end

  // ****************************************************
  // Direction
  // ****************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_q <= {NPORT{DIR_RST}};
    end else if (rif.wr_en) begin
      for (int p = 0; p < NPORT; p++) begin
        // RL2: direction field write
        if (rif.wr_addr == ADDR_DATA[p] && rif.wr_strb[DIR_STRB]) begin
          dir_q[p] <= rif.wr_data[DIR_LSB +: PW];
        end
      end
    end
  end

  // ****************************************************
  // Output values
  // ****************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q <= {NPORT{OUT_RST}};
    end else if (rif.wr_en && rif.wr_strb[OUT_STRB]) begin
      for (int p = 0; p < NPORT; p++) begin
        // RL3: output field write
        if (rif.wr_addr == ADDR_DATA[p]) begin
          out_q[p] <= rif.wr_data[OUT_LSB +: PW];
        end
        // RL6: set, ones only
        // RL8: other lanes ignored
        if (rif.wr_addr == ADDR_SET[p]) begin
          out_q[p] <= out_q[p] | rif.wr_data[OUT_LSB +: PW];
        end
        // RL7: clear, ones only
        if (rif.wr_addr == ADDR_CLR[p]) begin
          out_q[p] <= out_q[p] & ~rif.wr_data[OUT_LSB +: PW];
        end
      end
    end
  end

  // ****************************************************
  // Pull-up disables
  // ****************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pud_q <= {NPORT{PUD_RST}};
    end else if (rif.wr_en) begin
      for (int p = 0; p < NPORT; p++) begin
        for (int i = 0; i < PW; i++) begin
          // RL1: one bit per pin at 4n
          if (rif.wr_addr == ADDR_PAR[p] && rif.wr_strb[i/2]) begin
            pud_q[p][i] <= rif.wr_data[PUD_STEP*i];
          end
        end
      end
    end
  end

  // ****************************************************
  // Open-drain enables
  // ****************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oce_q <= {NPORT{OCE_RST}};
    end else if (rif.wr_en && rif.wr_strb[OCE_STRB]) begin
      for (int p = 1; p < NPORT; p++) begin
        // RL9: only capable pins kept
        if (rif.wr_addr == ADDR_OCE[p]) begin
          oce_q[p] <= rif.wr_data[PW-1:0] & OD_MASK[p];
        end
      end
    end
  end

  // ****************************************************
  // Read data
  // ****************************************************
  always_comb begin
    rif.rd_data = 32'h00000000;
    rif.rd_hit  = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      // RL4: captured field
      // RL5: live input field
      if (rif.rd_addr == ADDR_DATA[p]) begin
        rif.rd_hit  = 1'b1;
        rif.rd_data = {dir_q[p], out_q[p], rst_level[p], level[p]};
      end
      if (rif.rd_addr == ADDR_SET[p] || rif.rd_addr == ADDR_CLR[p]) begin
        rif.rd_hit = 1'b1;
      end
      if (rif.rd_addr == ADDR_PAR[p]) begin
        rif.rd_hit  = 1'b1;
        rif.rd_data = pud_spread(pud_q[p]);
      end
    end
    for (int p = 1; p < NPORT; p++) begin
      if (rif.rd_addr == ADDR_OCE[p]) begin
        rif.rd_hit  = 1'b1;
        rif.rd_data = {24'h000000, oce_q[p]};
      end
    end
  end

  // ****************************************************
  // Port pin logic
  // ****************************************************
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    // RL10: open-drain select per pin
    // RL12: level kept whatever the pin function
    // RL13: pull-up unless disabled
    // RL14: low for 0, float for 1
    gpp_port u_port (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .pin_in_i    (pin_in_i[PW*p +: PW]),
      .pin_out_o   (pin_out_o[PW*p +: PW]),
      .pin_oe_o    (pin_oe_o[PW*p +: PW]),
      .pullup_en_o (pullup_en_o[PW*p +: PW]),
      .out_i       (out_q[p]),
      .dir_i       (dir_q[p]),
      .od_i        (oce_q[p]),
      .pud_i       (pud_q[p]),
      .level_o     (level[p]),
      .rst_level_o (rst_level[p]),
      .cap_done_o  (cap_done[p])
    );
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_full_wr(logic [31:0] a);
    rif.wr_en && rif.wr_addr == a && rif.wr_strb == 4'hF;
  endsequence

  sequence s_in_steady;
    $stable(pin_in_i[7:0]) [*4];
  endsequence

  // RL1: pull-up map
  AST_PUD_MAP: assert property (s_full_wr(ADDR_PAR[0]) |=> // RL1
    pullup_en_o[7:0] == ~pud_gather($past(rif.wr_data)))
    else $error("pull-up bits not taken from positions 4n");

  // RL2: direction reaches pins
  AST_DIR_WR: assert property (s_full_wr(ADDR_DATA[1]) ##0 (oce_q[1] == 8'h00) |=> // RL2
    pin_oe_o[15:8] == $past(rif.wr_data[31:24]))
    else $error("direction write not seen on output enables");

  // RL3: output value reaches pins
  AST_OUT_WR: assert property (s_full_wr(ADDR_DATA[0]) |=> // RL3
    pin_out_o[7:0] == $past(rif.wr_data[23:16]))
    else $error("output write not seen on pins");

  // RL4: captured levels frozen
  AST_RST_HOLD: assert property (cap_done[0] |=> $stable(rst_level[0])) // RL4
    else $error("reset level field changed after capture");

  // RL5: steady pin seen in input field
  AST_IN_LEVEL: assert property (s_in_steady |-> level[0] == pin_in_i[7:0]) // RL5
    else $error("input field does not follow steady pin");

  // RL6: set ors in ones
  AST_SET: assert property (s_full_wr(ADDR_SET[2]) |=> // RL6
    out_q[2] == ($past(out_q[2]) | $past(rif.wr_data[23:16])))
    else $error("set register did not set output bits");

  // RL7: clear removes ones
  AST_CLR: assert property (s_full_wr(ADDR_CLR[3]) |=> // RL7
    out_q[3] == ($past(out_q[3]) & ~$past(rif.wr_data[23:16])))
    else $error("clear register did not clear output bits");

  // RL8: zero data leaves port alone
  AST_SET_RSVD: assert property (s_full_wr(ADDR_SET[0]) ##0 // RL8
    (rif.wr_data[23:16] == 8'h00) |=> $stable(out_q[0]) && $stable(dir_q[0]))
    else $error("reserved set bits changed the port");

  // RL9: no open-drain where absent
  AST_OD_MASK: assert property (oce_q[0] == 8'h00 && oce_q[1][5:0] == 6'h00) // RL9
    else $error("open-drain enabled on an incapable pin");

  // RL10: normal drive when disabled
  AST_OD_OFF: assert property (!oce_q[2][1] && dir_q[2][1] |-> // RL10
    pin_oe_o[17] && pin_out_o[17] == out_q[2][1])
    else $error("normal drive broken with open-drain off");

  // RL12: input field tracks pin on port 3 too
  AST_IN_ANY: assert property ($stable(pin_in_i[31:24]) [*4] |-> // RL12
    rif.rd_addr != ADDR_DATA[3] || rif.rd_data[7:0] == pin_in_i[31:24])
    else $error("input field lost the pin level");

  // RL13: disable bit removes pull-up
  AST_PULLUP: assert property (s_full_wr(ADDR_PAR[3]) ##0 rif.wr_data[0] |=> // RL13
    !pullup_en_o[24] ##1 !pullup_en_o[24] || rif.wr_en)
    else $error("pull-up still on after disable");

  // RL14: open-drain drive
  AST_OD_ON: assert property (oce_q[2][0] && dir_q[2][0] |-> // RL14
    pin_oe_o[16] == !out_q[2][0] && !pin_out_o[16])
    else $error("open-drain pin drives high");

endmodule

// File: sim/gpp_pin_model.sv
// Pin-side model: external drivers, pull-ups and floating pins
`timescale 1ns/100ps
module gpp_pin_model (
  // Clock
  input  wire logic        core_clk_i,
  // Device side
  input  wire logic [31:0] pin_out_i,
  input  wire logic [31:0] pin_oe_i,
  input  wire logic [31:0] pullup_en_i,
  // External drivers
  input  wire logic [31:0] ext_val_i,
  input  wire logic [31:0] ext_en_i,
  // Resolved levels
  output logic [31:0]      pin_lvl_o
);
  logic [31:0] last;

  always_ff @(posedge core_clk_i) begin
    last <= pin_lvl_o;
  end

  assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_val_i)
                   | (~pin_oe_i & ~ext_en_i & (pullup_en_i | ~last));
endmodule

// File: sim/tb_gpp_top.sv
// Register-level testbench for the four-port block
`timescale 1ns/100ps
module tb_gpp_top
  import gpp_pkg::*;
;
  localparam logic [31:0] RV = 32'hC35A3CA5;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, pin_lvl;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] dat, pout, poe, pue;
  logic [31:0] ext_val = RV, ext_en = 32'hFFFFFFFF;
  int          failures = 0, num_checks = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  gpp_top gpp_top_i (.core_clk_i(clk), .rst_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pin_in_i(pin_lvl),
    .pin_out_o(pout), .pin_oe_o(poe), .pullup_en_o(pue));

  gpp_pin_model gpp_pin_model_i (.core_clk_i(clk), .pin_out_i(pout), .pin_oe_i(poe),
    .pullup_en_i(pue), .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_lvl_o(pin_lvl));

  // ****************************************************
  // Bus tasks
  // ****************************************************
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1;
    rready  <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rsp = rresp;
    dat = rdata;
    rready <= 0;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    rd(a);
    chk({rsp, dat}, {2'h0, exp});
  endtask

  task automatic give_verdict;
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    give_verdict();
  end

  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    repeat (6) @(posedge clk);
    for (int p = 0; p < NPORT; p++) begin
      rc(ADDR_DATA[p], {16'h0, RV[8*p+:8], RV[8*p+:8]});
    end
    wr(ADDR_DATA[1], 32'h0F000000);
    chk({26'h0, poe[15:8]}, 34'h0F);
    wr(ADDR_DATA[1], 32'h00000000);
    wr(ADDR_SET[3], 32'h00F00000);
    wr(ADDR_CLR[3], 32'h00300000);
    rc(ADDR_DATA[3], 32'h00C0C3C3);
    wr(ADDR_PAR[3], 32'h00000001);
    chk({26'h0, pue[31:24]}, 34'hFE);
    wr(ADDR_DATA[0], 32'hFF5A1234);
    chk({32'h0, rsp}, 34'h0);
    chk({2'h0, poe[7:0], pout[7:0]}, 34'hFF5A);
    rc(ADDR_DATA[0], 32'hFF5AA55A);
    wr(ADDR_SET[0], 32'hFF81FFFF);
    rc(ADDR_DATA[0], 32'hFFDBA5DB);
    wr(ADDR_CLR[0], 32'hFF18FFFF);
    rc(ADDR_DATA[0], 32'hFFC3A5C3);
    wr(ADDR_SET[0], 32'hFF00FFFF);
    rc(ADDR_DATA[0], 32'hFFC3A5C3);
    wr(ADDR_PAR[0], 32'hFFFFFFFF);
    wr(ADDR_DATA[0], 32'h00C30000);
    rc(ADDR_PAR[0], 32'h11111111);
    chk({18'h0, pue[15:0]}, 34'hFF00);
    ext_val[15:8] <= 8'h96;
    repeat (2) @(posedge clk);
    rc(ADDR_DATA[1], 32'h00003C96);
    wr(ADDR_OCE[1], 32'hFFFFFFFF);
    rc(ADDR_OCE[1], 32'h000000C0);
    wr(ADDR_DATA[2], 32'h02020000);
    wr(ADDR_SET[2], 32'h00010000);
    chk({18'h0, poe[23:16], pout[23:16]}, 34'h0203);
    wr(ADDR_OCE[2], 32'hFFFFFFFF);
    rc(ADDR_OCE[2], 32'h000000FF);
    ext_en[23:16] <= 8'h00;
    wr(ADDR_DATA[2], 32'hFF0F0000);
    chk({18'h0, poe[23:16], pout[23:16]}, 34'hF000);
    rc(ADDR_DATA[2], 32'hFF0F5A0F);
    rd(32'hFFFF0D70);
    chk({rsp, dat}, {2'h2, 32'h0});
    wr(32'hFFFF0D70, 32'hFFFFFFFF);
    chk({32'h0, rsp}, 34'h2);
    give_verdict();
  end
endmodule
